// ### hdl/res_edge_defines.svh
// register indices, field positions, reset values and timing figures of the
// resonant edge-timing block; included by the design modules and by the test bench
`ifndef RES_EDGE_DEFINES_SVH
`define RES_EDGE_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_FOURTH_RISE 8'h4D
`define IDX_FOURTH_FALL 8'h4F
`define IDX_RECT1_RISE  8'h51
`define IDX_CONTROL     8'h60
`define IDX_STATUS      8'h61

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CTRL_RESONANT_BIT 0
`define STAT_FOURTH_BIT   0
`define STAT_RECT1_BIT    1
`define STAT_RESONANT_BIT 2
`define DELAY_RESET       8'h00
`define LEAD_SELECT_BIT   7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 20'h00008
`define STEP_NS       20'h00005
`define LEAD_MAX_NS   20'h00280

`endif

// ### hdl/res_edge_pkg.sv
// types shared by the resonant edge-timing modules
// assumes res_edge_defines.svh on the include path
package res_edge_pkg;

  localparam int NS_W = 20;

  typedef logic [NS_W-1:0] ns_t;

  typedef struct packed {
    ns_t  elapsed;
    logic running;
  } timer_state_t;

  typedef struct packed {
    logic [7:0] riseReg;
    logic [7:0] fallReg;
    logic [7:0] rectReg;
    logic       resonant;
    logic [7:0] riseShadow;
    logic [7:0] fallShadow;
    logic [7:0] rectShadow;
    logic       fourthOut;
    logic       rect1Out;
    logic       senseQ;
    logic [2:0] reachedQ;
    logic       waitQ;
    logic [7:0] readData;
  } edge_state_t;

endpackage

// ### hdl/edge_timer_if.sv
// start/target/reached bundle between the edge block and its delay timers
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface edge_timer_if;
  logic             start;
  res_edge_pkg::ns_t targetNs;
  logic             reached;

  modport timer (input start, input targetNs, output reached);
  modport user  (output start, output targetNs, input reached);
endinterface

// ### hdl/edge_delay_timer.sv
// elapsed-time counter in ns that raises reached once target is met
// assumes start is a one-cycle pulse in the clk_sys domain
`timescale 1ns/100ps
`include "res_edge_defines.svh"
module edge_delay_timer (
  input wire logic   clk_sys,
  input wire logic   srst,
  edge_timer_if.timer tmr
);

  res_edge_pkg::timer_state_t s_q;
  res_edge_pkg::timer_state_t s_d;

  // ----------------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------------
  // elapsed saturates so a missing restart never wraps into a false edge
  always_comb begin
    s_d = s_q;
    if (tmr.start) begin
      s_d.elapsed = '0;
      s_d.running = 1'b1;
    end else if (s_q.running && !(&s_q.elapsed[res_edge_pkg::NS_W-1:4])) begin
      s_d.elapsed = s_q.elapsed + `CLK_PERIOD_NS;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // least time rounds up: first sample with elapsed at or past the target
  assign tmr.reached = s_q.running && (s_q.elapsed >= tmr.targetNs);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_TIMER_STEP: assert property (tmr.start ##1 !tmr.start |=>
      s_q.elapsed == `CLK_PERIOD_NS)
    else $error("timer does not advance one clock period after start");
  AST_TIMER_RESTART: assert property (tmr.start |=> s_q.elapsed == '0 && s_q.running)
    else $error("timer not cleared by start");

endmodule

// ### hdl/resonant_edge_timing.sv
// edge placement for the fourth primary output and first rectifier output
// assumes a timebase giving a cycle-start pulse and the half period in clocks,
// and a line sense level synchronous to clk_sys
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "res_edge_defines.svh"

// Overview of operation
// (RULE1) rise code 0x00-0x7F trails midpoint, 5 ns steps
// (RULE2) rise code 0x80 leads midpoint by 640 ns
// (RULE3) higher lead codes shrink lead 5 ns each
// (RULE4) fall delayed from cycle end, code times 5 ns
// (RULE5) rectifier rise delayed from line sense rise
// (RULE6) edge timing acts only in resonant mode
// (RULE7) new settings taken at next cycle boundary
module resonant_edge_timing (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        cycleStart,
  input  wire logic [15:0] halfPeriod,
  input  wire logic        lineSenseSignal,
  output logic             fourthPrimaryOutput,
  output logic             firstRectifierOutput
);

  localparam int FALL_T = 0;
  localparam int RISE_T = 1;
  localparam int RECT_T = 2;

  res_edge_pkg::edge_state_t s_q;
  res_edge_pkg::edge_state_t s_d;
  res_edge_pkg::ns_t         midNs;
  res_edge_pkg::ns_t         trailNs;
  res_edge_pkg::ns_t         leadNs;
  res_edge_pkg::ns_t         riseTargetNs;
  logic [7:0]                regIndex;
  logic                      request;
  logic [2:0]                reached;
  logic [2:0]                hit;
  logic                      senseRise;

  edge_timer_if tmr[3] ();

  // ----------------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < 3; i++) begin : g_tmr
      edge_delay_timer u_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tmr     (tmr[i])
      );
      assign reached[i] = tmr[i].reached;
      assign hit[i]     = tmr[i].reached && !s_q.reachedQ[i];
    end
  endgenerate

  assign senseRise = lineSenseSignal && !s_q.senseQ;

  // ----------------------------------------------------------------------
  // edge targets in ns from the relevant reference
  // ----------------------------------------------------------------------
  assign midNs   = res_edge_pkg::NS_W'(32'(halfPeriod) * 32'(`CLK_PERIOD_NS));
  assign trailNs = res_edge_pkg::NS_W'(32'(s_q.riseShadow[6:0]) * 32'(`STEP_NS));
  // lead shrinks from 640 ns at the lowest lead code to 5 ns at the highest
  assign leadNs  = `LEAD_MAX_NS - trailNs; // see RULE2 see RULE3

  always_comb begin
    if (!s_q.riseShadow[`LEAD_SELECT_BIT]) begin
      riseTargetNs = midNs + trailNs; // see RULE1
    end else if (midNs > leadNs) begin
      riseTargetNs = midNs - leadNs; // see RULE2 see RULE3
    end else begin
      // a lead longer than half a cycle is clipped to the cycle start
      riseTargetNs = '0;
    end
  end

  assign tmr[FALL_T].start    = cycleStart;
  assign tmr[FALL_T].targetNs =
    res_edge_pkg::NS_W'(32'(s_q.fallShadow) * 32'(`STEP_NS)); // see RULE4
  assign tmr[RISE_T].start    = cycleStart;
  assign tmr[RISE_T].targetNs = riseTargetNs;
  assign tmr[RECT_T].start    = senseRise;
  assign tmr[RECT_T].targetNs =
    res_edge_pkg::NS_W'(32'(s_q.rectShadow) * 32'(`STEP_NS)); // see RULE5

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  assign regIndex = address[9:2];
  assign request  = read || write;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.senseQ   = lineSenseSignal;
    // a restart clears the edge memory: a timer left past its target by the
    // previous cycle would otherwise hide the edge of a zero delay
    s_d.reachedQ[FALL_T] = reached[FALL_T] && !cycleStart;
    s_d.reachedQ[RISE_T] = reached[RISE_T] && !cycleStart;
    s_d.reachedQ[RECT_T] = reached[RECT_T] && !senseRise;
    // one wait cycle per access keeps read data coming from a flop
    s_d.waitQ    = !(request && s_q.waitQ);

    if (request && s_q.waitQ) begin
      unique case (regIndex)
        `IDX_FOURTH_RISE: s_d.readData = s_q.riseReg;
        `IDX_FOURTH_FALL: s_d.readData = s_q.fallReg;
        `IDX_RECT1_RISE:  s_d.readData = s_q.rectReg;
        `IDX_CONTROL:     s_d.readData = {7'h00, s_q.resonant};
        `IDX_STATUS:      s_d.readData = {5'h00, s_q.resonant, s_q.rect1Out, s_q.fourthOut};
        default:          s_d.readData = 8'h00;
      endcase
    end

    if (write && !s_q.waitQ && byteenable[0]) begin
      unique case (regIndex)
        `IDX_FOURTH_RISE: s_d.riseReg  = writedata[7:0];
        `IDX_FOURTH_FALL: s_d.fallReg  = writedata[7:0];
        `IDX_RECT1_RISE:  s_d.rectReg  = writedata[7:0];
        `IDX_CONTROL:     s_d.resonant = writedata[`CTRL_RESONANT_BIT];
        default:          s_d.resonant = s_q.resonant;
      endcase
    end

    // shadows swap only at a cycle boundary so no pulse mixes old and new
    if (cycleStart) begin
      s_d.riseShadow = s_q.riseReg; // see RULE7
      s_d.fallShadow = s_q.fallReg; // see RULE7
      s_d.rectShadow = s_q.rectReg; // see RULE7
    end

    // fall wins over rise when both land on one clock
    if (hit[RISE_T]) begin
      s_d.fourthOut = 1'b1; // see RULE1
    end
    if (hit[FALL_T]) begin
      s_d.fourthOut = 1'b0; // see RULE4
    end
    if (hit[RECT_T] && lineSenseSignal) begin
      s_d.rect1Out = 1'b1; // see RULE5
    end
    if (!lineSenseSignal) begin
      s_d.rect1Out = 1'b0;
    end
    if (!s_q.resonant) begin
      s_d.fourthOut = 1'b0; // see RULE6
      s_d.rect1Out  = 1'b0; // see RULE6
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q            <= '0;
      s_q.riseReg    <= `DELAY_RESET;
      s_q.fallReg    <= `DELAY_RESET;
      s_q.rectReg    <= `DELAY_RESET;
      s_q.riseShadow <= `DELAY_RESET;
      s_q.fallShadow <= `DELAY_RESET;
      s_q.rectShadow <= `DELAY_RESET;
      s_q.waitQ      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata             = {24'h000000, s_q.readData};
  assign waitrequest          = s_q.waitQ;
  assign fourthPrimaryOutput  = s_q.fourthOut;
  assign firstRectifierOutput = s_q.rect1Out;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_TRAIL_TARGET: assert property ( // see RULE1
      !s_q.riseShadow[7] |-> riseTargetNs == midNs + 20'(s_q.riseShadow) * 20'h00005)
    else $error("trailing rise target wrong");
  AST_LEAD_640: assert property ( // see RULE2
      s_q.riseShadow == 8'h80 && midNs > 20'h00280 |-> midNs - riseTargetNs == 20'h00280)
    else $error("lowest lead code does not lead by 640 ns");
  AST_LEAD_STEP: assert property ( // see RULE3
      s_q.riseShadow[7] && midNs > 20'h00280 |->
      midNs - riseTargetNs == (20'h00100 - 20'(s_q.riseShadow)) * 20'h00005)
    else $error("lead does not shrink by 5 ns per code");
  AST_FALL_CLEARS: assert property ( // see RULE4
      hit[FALL_T] |=> !fourthPrimaryOutput)
    else $error("fourth output not cleared at fall delay");
  AST_FALL_ZERO: assert property ( // see RULE4
      cycleStart && s_q.fallReg == 8'h00 |=> ##1 !fourthPrimaryOutput)
    else $error("zero fall delay does not clear fourth output");
  AST_RECT_RISE: assert property ( // see RULE5
      hit[RECT_T] && lineSenseSignal && s_q.resonant |=> firstRectifierOutput)
    else $error("rectifier output not raised at its delay");
  AST_RESONANT_ONLY: assert property ( // see RULE6
      !s_q.resonant |=> !fourthPrimaryOutput && !firstRectifierOutput)
    else $error("outputs active outside resonant mode");
  AST_SHADOW_HOLD: assert property ( // see RULE7
      !cycleStart |=> $stable(s_q.fallShadow) && $stable(s_q.riseShadow)
                      && $stable(s_q.rectShadow))
    else $error("edge setting changed inside a cycle");
  AST_BUS_ANSWER: assert property (
      request && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle after request");

  COV_FOURTH_RISE: cover property (hit[RISE_T] && s_q.resonant);
  COV_LEAD_CODE:   cover property (s_q.riseShadow[7] && hit[RISE_T]);
  COV_RECT_RISE:   cover property (firstRectifierOutput);
  COV_REG_WRITE:   cover property (write && !waitrequest);
  COV_FALL_ZERO:   cover property (cycleStart && s_q.fallReg == 8'h00 && s_q.resonant);

endmodule

// ### sim/power_stage_model.sv
// switching-cycle timebase standing in for the power stage side
// assumes one clk_sys shared with the edge block; half period is PERIOD/2
`timescale 1ns/100ps
module power_stage_model #(
  parameter int PERIOD = 400
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  output logic             cycleStart,
  output logic      [15:0] halfPeriod,
  output logic      [15:0] cnt
);
  // ----------------------------------------------------------------
  // cycle counter: after an edge it reads clocks since the start plus one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst || cnt == 16'(PERIOD - 1)) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign cycleStart = (cnt == 16'h0000) && !srst;
  assign halfPeriod = 16'(PERIOD / 2);
endmodule

// ### sim/test_resonant_edge_timing.sv
// self-checking bench for the resonant edge-timing block
// assumes the power stage model gives the timebase; bench drives bus and line sense
`timescale 1ns/100ps
`include "res_edge_defines.svh"
module test_resonant_edge_timing;
  localparam int P = 400;
  localparam logic [9:0] A_RISE = {`IDX_FOURTH_RISE, 2'b00};
  localparam logic [9:0] A_FALL = {`IDX_FOURTH_FALL, 2'b00};
  localparam logic [9:0] A_RECT = {`IDX_RECT1_RISE, 2'b00};
  localparam logic [9:0] A_CTRL = {`IDX_CONTROL, 2'b00};
  logic        clk_sys, srst, read, write, waitrequest, cycleStart;
  logic        lineSenseSignal, fourthPrimaryOutput, firstRectifierOutput;
  logic [9:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [15:0] halfPeriod, cnt;
  int          errTotal, checkCount;

  resonant_edge_timing u_resonant_edge_timing (.clk_sys(clk_sys), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .cycleStart(cycleStart), .halfPeriod(halfPeriod), .lineSenseSignal(lineSenseSignal),
    .fourthPrimaryOutput(fourthPrimaryOutput), .firstRectifierOutput(firstRectifierOutput));
  power_stage_model #(.PERIOD(P)) u_power_stage_model (.clk_sys(clk_sys), .srst(srst),
    .cycleStart(cycleStart), .halfPeriod(halfPeriod), .cnt(cnt));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, 4'hF, q);
  endtask

  task automatic rdCheck(input string what, input logic [9:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'h0, q);
    check(what, {24'h000000, exp}, q);
  endtask

  // new settings only apply from a cycle start after the write
  task automatic syncCycle;
    do begin
      @(posedge clk_sys);
      #1;
    end while (cnt !== 16'h0001);
  endtask

  // edges until the chosen output changes to lvl, -1 if it never does
  task automatic waitEdge(input logic lvl, input bit rect, output int n);
    logic prev, now;
    n = -1;
    prev = rect ? firstRectifierOutput : fourthPrimaryOutput;
    for (int i = 1; i <= 2 * P && n < 0; i++) begin
      @(posedge clk_sys);
      #1;
      now = rect ? firstRectifierOutput : fourthPrimaryOutput;
      if (now === lvl && prev !== lvl) n = i;
      prev = now;
    end
  endtask

  function automatic int riseAt(logic [7:0] c);
    int t;
    t = (P / 2) * 8 + (c[7] ? -(640 - int'(c[6:0]) * 5) : int'(c) * 5);
    return (t + 7) / 8 + 2;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testRegs;
    logic [31:0] q;
    rdCheck("rise reset", A_RISE, 8'h00);
    rdCheck("fall reset", A_FALL, 8'h00);
    rdCheck("rect reset", A_RECT, 8'h00);
    wr(A_RISE, 8'hA5);
    wr(A_FALL, 8'h5A);
    wr(A_RECT, 8'hC3);
    bus(1'b1, A_RISE, 32'h0000003C, 4'hE, q);
    wr(10'h3FC, 8'hFF);
    rdCheck("rise rw", A_RISE, 8'hA5);
    rdCheck("fall rw", A_FALL, 8'h5A);
    rdCheck("rect rw", A_RECT, 8'hC3);
    rdCheck("unmapped", 10'h3FC, 8'h00);
  endtask

  task automatic testRise;
    logic [7:0] codes [6] = '{8'h00, 8'h40, 8'h7F, 8'h80, 8'hC0, 8'hFF};
    int n;
    wr(A_CTRL, 8'h01);
    rdCheck("ctrl", A_CTRL, 8'h01);
    wr(A_FALL, 8'h00);
    foreach (codes[i]) begin
      wr(A_RISE, codes[i]);
      syncCycle();
      waitEdge(1'b1, 1'b0, n);
      check("rise time", 32'(riseAt(codes[i])), 32'(cnt));
    end
  endtask

  task automatic testFall;
    logic [7:0] codes [3] = '{8'h01, 8'h08, 8'hFF};
    int n;
    wr(A_RISE, 8'h00);
    foreach (codes[i]) begin
      wr(A_FALL, codes[i]);
      syncCycle();
      waitEdge(1'b0, 1'b0, n);
      check("fall time", 32'((int'(codes[i]) * 5 + 7) / 8 + 2), 32'(cnt));
    end
  endtask

  // a write in mid-cycle must not change the pulse already under way
  task automatic testBoundary;
    int n;
    syncCycle();
    while (cnt < 16'h0032) @(posedge clk_sys);
    wr(A_RISE, 8'h7F);
    waitEdge(1'b1, 1'b0, n);
    check("old rise", 32'(riseAt(8'h00)), 32'(cnt));
    waitEdge(1'b1, 1'b0, n);
    check("new rise", 32'(riseAt(8'h7F)), 32'(cnt));
  endtask

  task automatic testRect;
    logic [7:0] codes [2] = '{8'h00, 8'hFF};
    int n;
    foreach (codes[i]) begin
      wr(A_RECT, codes[i]);
      syncCycle();
      @(posedge clk_sys);
      lineSenseSignal <= 1'b1;
      waitEdge(1'b1, 1'b1, n);
      check("rect rise", 32'((int'(codes[i]) * 5 + 7) / 8 + 2), 32'(n));
      @(posedge clk_sys);
      lineSenseSignal <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("rect low", 32'h0, {31'h0, firstRectifierOutput});
    end
  endtask

  task automatic testOff;
    int hits;
    hits = 0;
    wr(A_CTRL, 8'h00);
    lineSenseSignal <= 1'b1;
    repeat (P + 20) begin
      @(posedge clk_sys);
      #1;
      if (fourthPrimaryOutput !== 1'b0 || firstRectifierOutput !== 1'b0) hits++;
    end
    @(posedge clk_sys);
    lineSenseSignal <= 1'b0;
    check("outputs while off", 32'h0, 32'(hits));
  endtask

  task automatic summarize;
    if (errTotal == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // whole run is near 6k clocks; this allows about six times that
  initial begin
    #300_000;
    errTotal++;
    summarize();
  end

  initial begin
    errTotal = 0;
    checkCount = 0;
    srst = 1'b1;
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    lineSenseSignal = 1'b0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    testRegs();
    testRise();
    testFall();
    testBoundary();
    testRect();
    testOff();
    summarize();
  end
endmodule
